/* pkg/ovfm_pkg.sv */
// Purpose: Shared constants and carriers for the output voltage monitor
// Assumes: 40 MHz core clock, command codes as issued by the bus host
// Notes:   Threshold values are raw output-voltage codes, 1.953 mV a step
`default_nettype none
package ovfm_pkg;

    // Command codes of the monitor's registers
    localparam logic [7:0] CODE_OV_FAULT_LIM = 8'h40;
    localparam logic [7:0] CODE_OV_ACTION    = 8'h41;
    localparam logic [7:0] CODE_OV_WARN_LIM  = 8'h42;
    localparam logic [7:0] CODE_UV_WARN_LIM  = 8'h43;
    localparam logic [7:0] CODE_UV_FAULT_LIM = 8'h44;
    localparam logic [7:0] CODE_UV_ACTION    = 8'h45;

    // Defaults loaded at reset in place of the stored configuration
    localparam logic [15:0] RST_OV_FAULT_LIM = 16'h0161;
    localparam logic [7:0]  RST_OV_ACTION    = 8'hF8;
    localparam logic [15:0] RST_OV_WARN_LIM  = 16'h0151;
    localparam logic [15:0] RST_UV_WARN_LIM  = 16'h0114;
    localparam logic [15:0] RST_UV_FAULT_LIM = 16'h00F5;
    localparam logic [7:0]  RST_UV_ACTION    = 8'hB9;

    // Permitted ranges in codes: 0.3 V is 154 steps, 14 V is 7168 steps
    localparam logic [15:0] LIM_MIN_OV = 16'h009A;
    localparam logic [15:0] LIM_MIN_UV = 16'h0000;
    localparam logic [15:0] LIM_MAX    = 16'h1C00;

    // Action byte layout
    localparam int ACT_SEL_HI = 7;
    localparam int ACT_SEL_LO = 6;
    localparam int ACT_RTY_HI = 5;
    localparam int ACT_RTY_LO = 3;
    localparam int ACT_DLY_HI = 2;
    localparam int ACT_DLY_LO = 0;

    // Response selector encodings
    localparam logic [1:0] SEL_CONTINUE = 2'h0;
    localparam logic [1:0] SEL_UNUSED   = 2'h1;
    localparam logic [1:0] SEL_RESTART  = 2'h2;
    localparam logic [1:0] SEL_HOLD     = 2'h3;
    localparam logic [2:0] RTY_FOREVER  = 3'h7;

    // Restart delay unit, as time and as cycles of the core clock
    localparam int CLK_FREQ_HZ       = 40_000_000;
    localparam int RESTART_UNIT_MS   = 20;
    localparam int RESTART_UNIT_CYC  = (CLK_FREQ_HZ / 1000) * RESTART_UNIT_MS;

    // Command request from the bus front end
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  code;
        logic [15:0] wdata;
    } ovfm_cmd_s;

    // Answer to a command, one cycle after the request
    typedef struct packed {
        logic        ack;
        logic        err;
        logic [15:0] rdata;
    } ovfm_rsp_s;

    // Status levels shown to the host side
    typedef struct packed {
        logic ov_fault;
        logic uv_fault;
        logic ov_warn;
        logic uv_warn;
        logic ov_latched;
        logic uv_latched;
    } ovfm_stat_s;

endpackage
`default_nettype wire

/* tb/ovfm_host_model.sv */
// Purpose: Bus host model issuing monitor commands
// Assumes: Requests launched at falling edges, one at a time
// Notes:   Idle command fields carry inverted values, never stale ones
`default_nettype none
module ovfm_host_model
    import ovfm_pkg::*;
(
    // Clock
    input  wire logic      ref_clk_i,
    // Command port
    output var ovfm_cmd_s  cmd_o,
    input  wire ovfm_rsp_s rsp_i
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle at time zero
    initial cmd_o = '{wr: 1'b0, rd: 1'b0, code: 8'hA5, wdata: 16'h5A5A};

    // One command; bounded wait for its answer
    task automatic xfer(input logic wr, input logic [7:0] code,
                        input logic [15:0] wdata,
                        output ovfm_rsp_s rsp, output bit ok);
        ok = 1'b0;
        rsp = '0;
        @(negedge ref_clk_i);
        cmd_o = '{wr: wr, rd: !wr, code: code, wdata: wdata};
        @(negedge ref_clk_i);
        cmd_o = '{wr: 1'b0, rd: 1'b0, code: ~code, wdata: ~wdata};
        for (int n = 0; n < 3 && !ok; n++) begin
            if (rsp_i.ack === 1'b1) begin
                rsp = rsp_i;
                ok = 1'b1;
            end else begin
                @(negedge ref_clk_i);
            end
        end
    endtask
endmodule
`default_nettype wire

/* tb/ovfm_monitor_sva.sv */
// Purpose: Port-level assertions for the output voltage monitor
// Assumes: Selector shadows mirror every accepted action write
// Notes:   Shadows stand in for the action registers we cannot see
`default_nettype none
module ovfm_monitor_sva
    import ovfm_pkg::*;
#(
    parameter int UNIT_CYCLES = RESTART_UNIT_CYC
) (
    // Clock and reset
    input wire logic        ref_clk_i,
    input wire logic        rst_n_i,
    // Command port
    input wire ovfm_cmd_s   cmd_i,
    input wire ovfm_rsp_s   rsp_o,
    // Sensed output voltage
    input wire logic [15:0] vout_sample_i,
    input wire logic        vout_valid_i,
    // Run conditions
    input wire logic        ctrl_on_i,
    input wire logic        bias_ok_i,
    input wire logic        ext_fault_i,
    // Regulator side
    input wire logic        out_enable_o,
    input wire ovfm_stat_s  status_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] ov_sel_r;
    logic [1:0] uv_sel_r;
    logic       act_ok;
    logic       run;
    logic       req;

    // Selector 01 and nonzero upper bytes are refused
    assign act_ok = cmd_i.wr && cmd_i.wdata[15:8] == 8'h00
                    && cmd_i.wdata[7:6] != SEL_UNUSED;
    assign run = ctrl_on_i && bias_ok_i && !ext_fault_i;
    assign req = cmd_i.wr || cmd_i.rd;

    // Selector shadows, reset to the stored defaults
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ov_sel_r <= RST_OV_ACTION[7:6];
            uv_sel_r <= RST_UV_ACTION[7:6];
        end else if (act_ok && cmd_i.code == CODE_OV_ACTION) begin
            ov_sel_r <= cmd_i.wdata[7:6];
        end else if (act_ok && cmd_i.code == CODE_UV_ACTION) begin
            uv_sel_r <= cmd_i.wdata[7:6];
        end
    end

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // Undervoltage trip while hiccup restart is selected
    sequence s_uv_trip;
        $rose(status_o.uv_fault) && uv_sel_r == SEL_RESTART;
    endsequence

    chk_ack_follow: assert property (req |=> rsp_o.ack)
        else $error("no answer one cycle after a request");
    chk_ack_spurious: assert property (!req |=> !rsp_o.ack)
        else $error("answer without a request");
    chk_wr_rdata: assert property (cmd_i.wr |=> rsp_o.rdata == 16'h0000)
        else $error("write answer carries data");
    chk_bad_action: assert property (cmd_i.wr && cmd_i.code == CODE_OV_ACTION
        && !act_ok |=> rsp_o.err) else $error("bad action write accepted");
    chk_limit_range: assert property (cmd_i.wr
        && cmd_i.code == CODE_OV_FAULT_LIM && (cmd_i.wdata > LIM_MAX
        || cmd_i.wdata < LIM_MIN_OV) |=> rsp_o.err)
        else $error("out of range limit accepted");
    chk_unknown_rd: assert property (cmd_i.rd && !cmd_i.wr
        && (cmd_i.code < CODE_OV_FAULT_LIM || cmd_i.code > CODE_UV_ACTION)
        |=> rsp_o.err && rsp_o.rdata == 16'h0000)
        else $error("unknown code read not refused");
    chk_run_low_off: assert property (!run |=> !out_enable_o)
        else $error("output on while commanded off");
    chk_hold_off: assert property (status_o.ov_fault && ov_sel_r == SEL_HOLD
        |=> !out_enable_o) else $error("output on during held fault");
    chk_hold_resume: assert property ($fell(status_o.ov_fault)
        && ov_sel_r == SEL_HOLD && uv_sel_r == SEL_CONTINUE && run
        |=> out_enable_o) else $error("output not resumed after fault");
    chk_ignore_keeps: assert property (out_enable_o && run
        && ov_sel_r == SEL_CONTINUE && uv_sel_r == SEL_CONTINUE
        |=> out_enable_o) else $error("output dropped while ignoring");
    chk_uv_hiccup: assert property (s_uv_trip |=> !out_enable_o [*4])
        else $error("restart came too early");
endmodule
`default_nettype wire

/* tb/tb_ovfm_monitor.sv */
// Purpose: Self-checking bench for the output voltage monitor
// Assumes: Restart unit shortened to 8 cycles
// Notes:   Scenarios run in order and share register state
`default_nettype none
module tb_ovfm_monitor
    import ovfm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int UNIT = 8;
    logic        ref_clk_i;
    logic        rst_n_i;
    ovfm_cmd_s   cmd;
    ovfm_rsp_s   rsp;
    logic [15:0] vout;
    logic        vout_valid;
    logic        ctrl_on;
    logic        bias_ok;
    logic        ext_fault;
    logic        out_en;
    ovfm_stat_s  st;
    int          num_errors = 0;
    int          num_checks = 0;

    ovfm_monitor #(.UNIT_CYCLES(UNIT)) u_dut (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .cmd_i(cmd), .rsp_o(rsp),
        .vout_sample_i(vout), .vout_valid_i(vout_valid),
        .ctrl_on_i(ctrl_on), .bias_ok_i(bias_ok), .ext_fault_i(ext_fault),
        .out_enable_o(out_en), .status_o(st));
    ovfm_host_model u_host (
        .ref_clk_i(ref_clk_i), .cmd_o(cmd), .rsp_i(rsp));

    // Free-running 40 MHz clock
    initial begin
        ref_clk_i = 1'b0;
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end

    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] seen,
                         input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // A lost answer ends the run at once
    task automatic bus(input logic wr, input logic [7:0] code,
                       input logic [15:0] wdata, output ovfm_rsp_s r);
        bit ok;
        u_host.xfer(wr, code, wdata, r, ok);
        if (!ok) begin
            num_errors++;
            $display("[FAIL] ack expected 1 seen 0");
            summarize();
        end
    endtask

    // Status needs two cycles and the enable three; five leaves margin
    task automatic settle(input logic [15:0] v);
        @(negedge ref_clk_i);
        vout = v;
        repeat (5) @(negedge ref_clk_i);
    endtask

    task automatic t_defaults();
        ovfm_rsp_s   r;
        logic [15:0] exp [6] = '{RST_OV_FAULT_LIM, 16'(RST_OV_ACTION),
            RST_OV_WARN_LIM, RST_UV_WARN_LIM, RST_UV_FAULT_LIM,
            16'(RST_UV_ACTION)};
        for (int i = 0; i < 6; i++) begin
            bus(1'b0, 8'(8'h40 + i), 16'h0000, r);
            check("default", r.rdata, exp[i]);
        end
        bus(1'b0, 8'h46, 16'h0000, r);
        check("unknown read err", 16'(r.err), 16'h0001);
    endtask

    task automatic t_writes();
        ovfm_rsp_s   r;
        logic [7:0]  c [9] = '{8'h40, 8'h40, 8'h40, 8'h40, 8'h41, 8'h41,
                               8'h45, 8'h43, 8'h43};
        logic [15:0] d [9] = '{16'h1C01, 16'h0099, 16'h009A, 16'h0200,
            16'h0040, 16'h01F8, 16'h0091, 16'h0000, 16'h0114};
        logic [8:0]  e = 9'h033;
        logic [15:0] q [4] = '{16'h0200, 16'h00F8, 16'h0091, 16'h0114};
        for (int i = 0; i < 9; i++) begin
            bus(1'b1, c[i], d[i], r);
            check("write err", 16'(r.err), 16'(e[i]));
        end
        for (int i = 0; i < 4; i++) begin
            bus(1'b0, c[2 * i + 2], 16'h0000, r);
            check("readback", r.rdata, q[i]);
        end
    endtask

    task automatic t_ignore();
        ovfm_rsp_s r;
        bus(1'b1, 8'h41, 16'h0000, r);
        bus(1'b1, 8'h45, 16'h0000, r);
        settle(16'h0300);
        check("ov fault", 16'(st.ov_fault), 16'h0001);
        check("enable ov ignored", 16'(out_en), 16'h0001);
        settle(16'h0000);
        check("uv fault", 16'(st.uv_fault), 16'h0001);
        check("enable uv ignored", 16'(out_en), 16'h0001);
        settle(16'h0130);
    endtask

    task automatic t_hold();
        ovfm_rsp_s r;
        bus(1'b1, 8'h41, 16'h00C0, r);
        settle(16'h0201);
        check("ov fault above", 16'(st.ov_fault), 16'h0001);
        check("ov warn", 16'(st.ov_warn), 16'h0001);
        check("enable held", 16'(out_en), 16'h0000);
        settle(16'h0200);
        check("ov fault at limit", 16'(st.ov_fault), 16'h0000);
        check("enable resumed", 16'(out_en), 16'h0001);
    endtask

    task automatic t_warn();
        vout_valid = 1'b0;
        settle(16'h0300);
        check("sample held", 16'(st.ov_fault), 16'h0000);
        vout = 16'h0152;
        vout_valid = 1'b1;
        settle(16'h0152);
        check("warn high", 16'({st.ov_warn, st.ov_fault}), 16'h0002);
        check("enable warn high", 16'(out_en), 16'h0001);
        settle(16'h0113);
        check("warn low", 16'({st.uv_warn, st.uv_fault}), 16'h0002);
        check("enable warn low", 16'(out_en), 16'h0001);
    endtask

    task automatic t_default_ov();
        ovfm_rsp_s  r;
        logic [2:0] k [3] = '{3'h2, 3'h4, 3'h7};
        bus(1'b1, 8'h41, 16'h00F8, r);
        settle(16'h0300);
        check("enable off ov", 16'(out_en), 16'h0000);
        settle(16'h0130);
        check("enable back", 16'(out_en), 16'h0001);
        for (int i = 0; i < 3; i++) begin
            {ctrl_on, bias_ok, ext_fault} = k[i];
            settle(16'h0130);
            check("enable run low", 16'(out_en), 16'h0000);
            {ctrl_on, bias_ok, ext_fault} = 3'h6;
            settle(16'h0130);
            check("enable run high", 16'(out_en), 16'h0001);
        end
    endtask

    // Count restart attempts while the fault stays present
    task automatic t_uv_hiccup();
        ovfm_rsp_s r;
        int        rises = 0;
        logic      prev = 1'b0;
        bus(1'b1, 8'h45, 16'h0091, r);
        settle(16'h00F0);
        repeat (30) @(negedge ref_clk_i);
        check("latch", 16'({st.ov_latched, st.uv_latched}), 16'h1);
        ctrl_on = 1'b0;
        bus(1'b1, 8'h45, 16'h00B9, r);
        ctrl_on = 1'b1;
        settle(16'h00F0);
        check("enable uv off", 16'(out_en), 16'h0000);
        for (int i = 0; i < 60; i++) begin
            @(negedge ref_clk_i);
            rises += int'(out_en === 1'b1 && prev === 1'b0);
            prev = out_en;
        end
        check("restarts", 16'(rises >= 3), 16'h0001);
        settle(16'h0130);
        repeat (20) @(negedge ref_clk_i);
        check("enable uv clear", 16'(out_en), 16'h0001);
    endtask

    // Main sequence
    initial begin
        rst_n_i = 1'b0;
        vout = 16'h0130;
        vout_valid = 1'b1;
        {ctrl_on, bias_ok, ext_fault} = 3'h6;
        repeat (3) @(negedge ref_clk_i);
        rst_n_i = 1'b1;
        repeat (30) @(negedge ref_clk_i);
        t_defaults();
        t_writes();
        t_ignore();
        t_hold();
        t_warn();
        t_default_ov();
        t_uv_hiccup();
        rst_n_i = 1'b0;
        @(negedge ref_clk_i);
        rst_n_i = 1'b1;
        t_defaults();
        summarize();
    end
endmodule

bind ovfm_monitor ovfm_monitor_sva #(.UNIT_CYCLES(UNIT_CYCLES)) u_sva (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .cmd_i(cmd_i), .rsp_o(rsp_o),
    .vout_sample_i(vout_sample_i), .vout_valid_i(vout_valid_i),
    .ctrl_on_i(ctrl_on_i), .bias_ok_i(bias_ok_i),
    .ext_fault_i(ext_fault_i), .out_enable_o(out_enable_o),
    .status_o(status_o));
`default_nettype wire

/* verilog/ovfm_fault_resp.sv */
// Purpose: Reaction of the regulator output to one kind of fault
// Assumes: run_i low means commanded off, bias lost or other shutdown
// Notes:   Restart delay is the delay field times one unit, at least one
`default_nettype none
module ovfm_fault_resp
    import ovfm_pkg::*;
#(
    parameter int UNIT_CYCLES = RESTART_UNIT_CYC
) (
    // Clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       rst_n_i,
    // Conditions
    input  wire logic       run_i,
    input  wire logic       fault_i,
    input  wire logic [7:0] action_i,
    // Results
    output logic            allow_o,
    output logic            latched_o
);

    localparam int CNT_W = $clog2(UNIT_CYCLES * 8 + 1);

    typedef enum logic [1:0] {ST_RUN, ST_HOLD, ST_WAIT, ST_LATCH} ovfm_st_e;

    ovfm_st_e         state_r;
    logic [2:0]       tries_r;
    logic [CNT_W-1:0] cnt_r;
    logic [1:0]       sel;
    logic [2:0]       rty;
    logic [2:0]       dly;
    logic             may_retry;
    logic [CNT_W-1:0] wait_len;

    // Field split of the action byte
    assign sel = action_i[ACT_SEL_HI:ACT_SEL_LO];
    assign rty = action_i[ACT_RTY_HI:ACT_RTY_LO];
    assign dly = action_i[ACT_DLY_HI:ACT_DLY_LO];
    assign may_retry = (rty == RTY_FOREVER) || (tries_r < rty);
    // Zero delay still waits one unit so a hiccup never spins
    assign wait_len = CNT_W'(UNIT_CYCLES * ((dly == 3'h0) ? 1 : int'(dly)));

    // Response sequence
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r <= ST_RUN;
            tries_r <= 3'h0;
            cnt_r   <= '0;
        end else if (!run_i) begin
            // Commanded off ends retries and clears any latch
            state_r <= ST_RUN;
            tries_r <= 3'h0;
            cnt_r   <= '0;
        end else begin
            case (state_r)
                ST_RUN: begin
                    if (fault_i) begin
                        case (sel)
                            SEL_HOLD: state_r <= ST_HOLD;
                            SEL_RESTART: begin
                                if (may_retry) begin
                                    state_r <= ST_WAIT;
                                    cnt_r   <= wait_len;
                                end else begin
                                    state_r <= ST_LATCH;
                                end
                            end
                            default: state_r <= ST_RUN;
                        endcase
                    end
                end
                ST_HOLD: begin
                    if (!fault_i || sel != SEL_HOLD) begin
                        state_r <= ST_RUN;
                    end
                end
                ST_WAIT: begin
                    if (cnt_r <= CNT_W'(1)) begin
                        state_r <= ST_RUN;
                        if (rty != RTY_FOREVER) begin
                            tries_r <= tries_r + 3'h1;
                        end
                    end else begin
                        cnt_r <= cnt_r - CNT_W'(1);
                    end
                end
                ST_LATCH: state_r <= ST_LATCH;
                default:  state_r <= ST_RUN;
            endcase
        end
    end

    assign allow_o   = (state_r == ST_RUN);
    assign latched_o = (state_r == ST_LATCH);

endmodule
`default_nettype wire

/* verilog/ovfm_limit_reg.sv */
// Purpose: One 16-bit voltage threshold with range check and comparator
// Assumes: Writes arrive as single-cycle strobes
// Notes:   An out-of-range write leaves the stored value untouched
`default_nettype none
module ovfm_limit_reg
    import ovfm_pkg::*;
#(
    parameter logic [15:0] RST_VAL = 16'h0000,
    parameter logic [15:0] MIN_VAL = 16'h0000,
    parameter logic [15:0] MAX_VAL = 16'h1C00,
    parameter bit          ABOVE   = 1'b1
) (
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    // Write port
    input  wire logic        wr_i,
    input  wire logic [15:0] wdata_i,
    // Sensed voltage
    input  wire logic [15:0] vout_i,
    // Results
    output logic      [15:0] value_o,
    output logic             bad_o,
    output logic             cross_o
);

    // Every integer code is on the step grid, so only the range can fail
    assign bad_o = (wdata_i < MIN_VAL) || (wdata_i > MAX_VAL);

    // Stored threshold, default loaded at reset
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            value_o <= RST_VAL;
        end else if (wr_i && !bad_o) begin
            value_o <= wdata_i;
        end
    end

    // Strictly above or strictly below the threshold
    assign cross_o = ABOVE ? (vout_i > value_o) : (vout_i < value_o);

endmodule
`default_nettype wire

/* verilog/ovfm_monitor.sv */
// Purpose: Output voltage fault and warning supervision with its registers
// Assumes: Commands arrive decoded by the bus front end as code plus data
// Notes:   Answers come one cycle after each request, from flip-flops
`default_nettype none
module ovfm_monitor
    import ovfm_pkg::*;
#(
    parameter int UNIT_CYCLES = RESTART_UNIT_CYC
) (
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    // Command port
    input  wire ovfm_cmd_s   cmd_i,
    output ovfm_rsp_s        rsp_o,
    // Sensed output voltage
    input  wire logic [15:0] vout_sample_i,
    input  wire logic        vout_valid_i,
    // Run conditions from the controller core
    input  wire logic        ctrl_on_i,
    input  wire logic        bias_ok_i,
    input  wire logic        ext_fault_i,
    // Regulator control and status
    output logic             out_enable_o,
    output ovfm_stat_s       status_o
);

    logic [15:0] vout_r;
    logic [7:0]  ov_action_r;
    logic [7:0]  uv_action_r;
    logic [15:0] ov_fault_lim;
    logic [15:0] ov_warn_lim;
    logic [15:0] uv_warn_lim;
    logic [15:0] uv_fault_lim;
    logic        ov_fault_bad;
    logic        ov_warn_bad;
    logic        uv_warn_bad;
    logic        uv_fault_bad;
    logic        ov_cross;
    logic        ov_warn_cross;
    logic        uv_warn_cross;
    logic        uv_cross;
    logic        wr_ov_fault;
    logic        wr_ov_warn;
    logic        wr_uv_warn;
    logic        wr_uv_fault;
    logic        wr_ov_action;
    logic        wr_uv_action;
    logic        ov_action_bad;
    logic        uv_action_bad;
    logic        wr_known;
    logic        wr_bad;
    logic        run;
    logic        ov_allow;
    logic        uv_allow;
    logic        ov_latched;
    logic        uv_latched;
    logic [15:0] rd_mux;
    logic        rd_known;

    // Hold the latest valid sample so the comparators see a stable value
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            vout_r <= 16'h0000;
        end else if (vout_valid_i) begin
            vout_r <= vout_sample_i;
        end
    end

    // Write decode by command code
    assign wr_ov_fault  = cmd_i.wr && (cmd_i.code == CODE_OV_FAULT_LIM);
    assign wr_ov_warn   = cmd_i.wr && (cmd_i.code == CODE_OV_WARN_LIM);
    assign wr_uv_warn   = cmd_i.wr && (cmd_i.code == CODE_UV_WARN_LIM);
    assign wr_uv_fault  = cmd_i.wr && (cmd_i.code == CODE_UV_FAULT_LIM);
    assign wr_ov_action = cmd_i.wr && (cmd_i.code == CODE_OV_ACTION);
    assign wr_uv_action = cmd_i.wr && (cmd_i.code == CODE_UV_ACTION);

    // Overvoltage fault threshold
    ovfm_limit_reg #(
        .RST_VAL (RST_OV_FAULT_LIM),
        .MIN_VAL (LIM_MIN_OV),
        .MAX_VAL (LIM_MAX),
        .ABOVE   (1'b1)
    ) u_ov_fault_lim (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .wr_i      (wr_ov_fault),
        .wdata_i   (cmd_i.wdata),
        .vout_i    (vout_r),
        .value_o   (ov_fault_lim),
        .bad_o     (ov_fault_bad),
        .cross_o   (ov_cross)
    );

    // Overvoltage warning threshold
    ovfm_limit_reg #(
        .RST_VAL (RST_OV_WARN_LIM),
        .MIN_VAL (LIM_MIN_OV),
        .MAX_VAL (LIM_MAX),
        .ABOVE   (1'b1)
    ) u_ov_warn_lim (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .wr_i      (wr_ov_warn),
        .wdata_i   (cmd_i.wdata),
        .vout_i    (vout_r),
        .value_o   (ov_warn_lim),
        .bad_o     (ov_warn_bad),
        .cross_o   (ov_warn_cross)
    );

    // Undervoltage warning threshold
    ovfm_limit_reg #(
        .RST_VAL (RST_UV_WARN_LIM),
        .MIN_VAL (LIM_MIN_UV),
        .MAX_VAL (LIM_MAX),
        .ABOVE   (1'b0)
    ) u_uv_warn_lim (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .wr_i      (wr_uv_warn),
        .wdata_i   (cmd_i.wdata),
        .vout_i    (vout_r),
        .value_o   (uv_warn_lim),
        .bad_o     (uv_warn_bad),
        .cross_o   (uv_warn_cross)
    );

    // Undervoltage fault threshold
    ovfm_limit_reg #(
        .RST_VAL (RST_UV_FAULT_LIM),
        .MIN_VAL (LIM_MIN_UV),
        .MAX_VAL (LIM_MAX),
        .ABOVE   (1'b0)
    ) u_uv_fault_lim (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .wr_i      (wr_uv_fault),
        .wdata_i   (cmd_i.wdata),
        .vout_i    (vout_r),
        .value_o   (uv_fault_lim),
        .bad_o     (uv_fault_bad),
        .cross_o   (uv_cross)
    );

    // Action bytes: upper data bits must be zero, selector 01 unsupported
    assign ov_action_bad = (cmd_i.wdata[15:8] != 8'h00) ||
        (cmd_i.wdata[ACT_SEL_HI:ACT_SEL_LO] == SEL_UNUSED);
    assign uv_action_bad = ov_action_bad;

    // Overvoltage action register
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ov_action_r <= RST_OV_ACTION;
        end else if (wr_ov_action && !ov_action_bad) begin
            ov_action_r <= cmd_i.wdata[7:0];
        end
    end

    // Undervoltage action register
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            uv_action_r <= RST_UV_ACTION;
        end else if (wr_uv_action && !uv_action_bad) begin
            uv_action_r <= cmd_i.wdata[7:0];
        end
    end

    // Write error: unknown code or rejected value
    assign wr_known = wr_ov_fault || wr_ov_warn || wr_uv_warn ||
                      wr_uv_fault || wr_ov_action || wr_uv_action;
    assign wr_bad = (wr_ov_fault && ov_fault_bad) ||
                    (wr_ov_warn && ov_warn_bad) ||
                    (wr_uv_warn && uv_warn_bad) ||
                    (wr_uv_fault && uv_fault_bad) ||
                    (wr_ov_action && ov_action_bad) ||
                    (wr_uv_action && uv_action_bad);

    // Read multiplexer; action bytes sit in the low byte
    always_comb begin
        rd_mux   = 16'h0000;
        rd_known = 1'b1;
        case (cmd_i.code)
            CODE_OV_FAULT_LIM: rd_mux = ov_fault_lim;
            CODE_OV_ACTION:    rd_mux = {8'h00, ov_action_r};
            CODE_OV_WARN_LIM:  rd_mux = ov_warn_lim;
            CODE_UV_WARN_LIM:  rd_mux = uv_warn_lim;
            CODE_UV_FAULT_LIM: rd_mux = uv_fault_lim;
            CODE_UV_ACTION:    rd_mux = {8'h00, uv_action_r};
            default:           rd_known = 1'b0;
        endcase
    end

    // Registered answer, one cycle after the request
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rsp_o <= '0;
        end else begin
            rsp_o.ack   <= cmd_i.wr || cmd_i.rd;
            rsp_o.err   <= (cmd_i.wr && (!wr_known || wr_bad)) ||
                           (cmd_i.rd && !cmd_i.wr && !rd_known);
            rsp_o.rdata <= (cmd_i.rd && !cmd_i.wr) ? rd_mux : 16'h0000;
        end
    end

    // Regulation is wanted only while commanded on with bias present and no external fault
    assign run = ctrl_on_i && bias_ok_i && !ext_fault_i;

    // Overvoltage reaction
    ovfm_fault_resp #(
        .UNIT_CYCLES (UNIT_CYCLES)
    ) u_ov_resp (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .run_i     (run),
        .fault_i   (ov_cross),
        .action_i  (ov_action_r),
        .allow_o   (ov_allow),
        .latched_o (ov_latched)
    );

    // Undervoltage reaction
    ovfm_fault_resp #(
        .UNIT_CYCLES (UNIT_CYCLES)
    ) u_uv_resp (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .run_i     (run),
        .fault_i   (uv_cross),
        .action_i  (uv_action_r),
        .allow_o   (uv_allow),
        .latched_o (uv_latched)
    );

    // Output enable; warnings deliberately take no part here
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            out_enable_o <= 1'b0;
        end else begin
            out_enable_o <= run && ov_allow && uv_allow;
        end
    end

    // Status levels follow the comparators and the latch states one cycle later
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            status_o <= '0;
        end else begin
            status_o.ov_fault   <= ov_cross;
            status_o.uv_fault   <= uv_cross;
            status_o.ov_warn    <= ov_warn_cross;
            status_o.uv_warn    <= uv_warn_cross;
            status_o.ov_latched <= ov_latched;
            status_o.uv_latched <= uv_latched;
        end
    end

endmodule
`default_nettype wire
